// ===== include/etf_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz pclk
// Notes: Definitions only
`ifndef ETF_REGS_SVH
`define ETF_REGS_SVH
`define ETF_CLK_NS 10
`define ETF_DW 512
`define ETF_LANES 4
`define ETF_LANE_W 128
`define ETF_BUF_DEPTH 4'h8
`define ETF_BP_LEVEL 4'h5
`define ETF_LINE_DIV 2'h1
`define ETF_AM_SPACING 14'h3fff
`define ETF_BER_WIN 10'h3ff
`define ETF_BER_DEN 10000
`define ETF_SETTLE_NS 10000
`define ETF_ALIGN_TO_NS 1000000
// Register offsets
`define ETF_OFF_CTRL 8'h00
`define ETF_OFF_CFG 8'h04
`define ETF_OFF_STAT 8'h08
`define ETF_OFF_IRQ_ST 8'h0c
`define ETF_OFF_IRQ_CLR 8'h10
`define ETF_OFF_IRQ_EN 8'h14
`define ETF_OFF_CNT_PKT 8'h18
`define ETF_OFF_CNT_BIP 8'h1c
// CTRL fields
`define ETF_CTRL_SWRST 0
`define ETF_CTRL_LOOP 1
`define ETF_CTRL_RXRST 2
`define ETF_CTRL_RESUME 3
`define ETF_CTRL_TIMEOUT 4
`define ETF_CTRL_RST 5'h00
// Interrupt bits
`define ETF_IRQ_OVF 0
`define ETF_IRQ_UNF 1
`define ETF_IRQ_HIBER 2
`define ETF_IRQ_BIP 3
`define ETF_IRQ_CDR 4
`define ETF_IRQ_W 5
`endif

// ===== include/etf_pkg.sv
// Purpose: Shared types and helpers
// Assumes: etf_regs.svh constants
// Notes: Nothing here holds state
`include "etf_regs.svh"
package etf_pkg;
  typedef logic [`ETF_DW-1:0] etf_data_t;
  typedef logic [8*`ETF_LANES-1:0] etf_bip_t;
  typedef enum logic [1:0] {ST_HOLD, ST_RUN} etf_rst_st_t;

  // Per-lane interleaved parity, eight bits per lane
  function automatic etf_bip_t etf_bip(input etf_data_t d);
    etf_bip_t b;
    b = '0;
    for (int i = 0; i < `ETF_DW; i++) begin
      b[(i / `ETF_LANE_W) * 8 + i % 8] ^= d[i];
    end
    return b;
  endfunction : etf_bip

  function automatic logic [2:0] etf_ones(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction : etf_ones
endpackage : etf_pkg

// ===== include/etf_if.sv
// Purpose: Link between user-side controller and the MAC transmit core
// Assumes: Both ends on pclk
// Notes: No clocking block
`timescale 1ns/1ps
interface etf_if (
  input wire logic pclk
);
  logic core_rst_n;
  logic rx_dp_rst;
  logic [13:0] cfg_am_spacing;
  logic loopback;
  logic tx_valid;
  logic tx_sop;
  logic tx_eop;
  etf_pkg::etf_data_t tx_data;
  logic tx_backpressure;
  logic tx_overflow;
  logic tx_underflow;
  logic [3:0] rx_bip_err;
  logic rx_high_error_rate;
  logic rx_aligned;
  logic stat_tx_pkt;
  logic [2:0] stat_rx_bip_cnt;

  modport dev (
    input core_rst_n, rx_dp_rst, cfg_am_spacing, loopback,
    input tx_valid, tx_sop, tx_eop, tx_data,
    output tx_backpressure, tx_overflow, tx_underflow,
    output rx_bip_err, rx_high_error_rate, rx_aligned,
    output stat_tx_pkt, stat_rx_bip_cnt
  );
  modport host (
    output core_rst_n, rx_dp_rst, cfg_am_spacing, loopback,
    output tx_valid, tx_sop, tx_eop, tx_data,
    input tx_backpressure, tx_overflow, tx_underflow,
    input rx_bip_err, rx_high_error_rate, rx_aligned,
    input stat_tx_pkt, stat_rx_bip_cnt
  );
endinterface : etf_if

// ===== verilog/etf_rxmon.sv
// Purpose: Receive lane parity check and high error rate flag
// Assumes: One received beat per valid, parity word beside it
// Notes: Cleared by core or receive datapath reset
`timescale 1ns/1ps
`include "etf_regs.svh"
module etf_rxmon (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic rx_valid,
  input wire logic rx_am,
  input etf_pkg::etf_data_t rx_data,
  input etf_pkg::etf_bip_t rx_bip,
  output logic [3:0] bip_err_q,
  output logic [2:0] bip_cnt_q,
  output logic hi_ber_q,
  output logic aligned_q
);
  // Errors allowed per window of 1024 beats at 512 bits each
  localparam logic [15:0] LIMIT = 16'(1024 * `ETF_DW / `ETF_BER_DEN);

  logic [9:0] win_q;
  logic [15:0] acc_q;
  etf_pkg::etf_bip_t diff;
  logic [3:0] lane_err;
  logic [15:0] acc_next;

  assign diff = etf_pkg::etf_bip(rx_data) ^ rx_bip;
  assign lane_err = {|diff[31:24], |diff[23:16], |diff[15:8], |diff[7:0]};
  assign acc_next = acc_q + 16'(etf_pkg::etf_ones(lane_err));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bip_err_q <= 4'h0;
      bip_cnt_q <= 3'h0;
      hi_ber_q <= 1'b0;
      aligned_q <= 1'b0;
      win_q <= 10'h000;
      acc_q <= 16'h0000;
    end else if (clr) begin
      bip_err_q <= 4'h0;
      bip_cnt_q <= 3'h0;
      hi_ber_q <= 1'b0;
      aligned_q <= 1'b0;
      win_q <= 10'h000;
      acc_q <= 16'h0000;
    end else begin
      bip_err_q <= rx_valid ? lane_err : 4'h0;
      bip_cnt_q <= rx_valid ? etf_pkg::etf_ones(lane_err) : 3'h0;
      if (rx_am) begin
        aligned_q <= 1'b1;
      end
      if (rx_valid) begin
        win_q <= win_q + 10'h001;
        if (win_q == `ETF_BER_WIN) begin
          hi_ber_q <= acc_next > LIMIT;
          acc_q <= 16'h0000;
        end else begin
          acc_q <= acc_next;
        end
      end
    end
  end
endmodule : etf_rxmon

// ===== verilog/etf_dev.sv
// Purpose: Transmit buffer with flow control, line side and receive health
// Assumes: Line pins are on pclk (transceiver side modelled as logic)
// Notes: Line drains one beat every other cycle, slower than the bus
`timescale 1ns/1ps
`include "etf_regs.svh"
module etf_dev (
  input wire logic pclk,
  input wire logic presetn,
  etf_if.dev lnk,
  output logic line_tx_valid_q,
  output logic line_tx_am_q,
  output etf_pkg::etf_data_t line_tx_data_q,
  output etf_pkg::etf_bip_t line_tx_bip_q,
  input wire logic line_rx_valid,
  input wire logic line_rx_am,
  input etf_pkg::etf_data_t line_rx_data,
  input etf_pkg::etf_bip_t line_rx_bip
);
  etf_pkg::etf_data_t mem_q [8];
  logic [7:0] sop_q;
  logic [7:0] eop_q;
  logic [2:0] wp_q;
  logic [2:0] rp_q;
  logic [3:0] fill_q;
  logic [1:0] div_q;
  logic [13:0] am_cnt_q;
  logic [13:0] am_cfg_q;
  logic in_pkt_q;
  logic bp_q;
  logic ovf_q;
  logic unf_q;
  logic pkt_q;

  // ----------------------------------------------------------------
  // Buffer control
  // ----------------------------------------------------------------
  wire full = fill_q == `ETF_BUF_DEPTH;
  wire empty = fill_q == 4'h0;
  wire line_en = div_q == `ETF_LINE_DIV;
  wire am_slot = line_en && (am_cnt_q == am_cfg_q);
  wire wr = lnk.tx_valid && !full;
  wire rd = line_en && !am_slot && !empty;
  wire starve = line_en && !am_slot && empty && in_pkt_q;
  wire [3:0] fill_d = fill_q + {3'h0, wr} - {3'h0, rd};

  always_ff @(posedge pclk) begin
    if (wr) begin
      mem_q[wp_q] <= lnk.tx_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sop_q, eop_q, wp_q, rp_q, fill_q, div_q} <= 28'h0000000;
      {am_cnt_q, in_pkt_q, bp_q, ovf_q, unf_q, pkt_q} <= 19'h00000;
      am_cfg_q <= `ETF_AM_SPACING;
      line_tx_valid_q <= 1'b0;
      line_tx_am_q <= 1'b0;
      line_tx_data_q <= '0;
      line_tx_bip_q <= '0;
    end else if (!lnk.core_rst_n) begin
      // New settings taken only while held in reset
      am_cfg_q <= lnk.cfg_am_spacing;
      {sop_q, eop_q, wp_q, rp_q, fill_q, div_q} <= 28'h0000000;
      {am_cnt_q, in_pkt_q, bp_q, ovf_q, unf_q, pkt_q} <= 19'h00000;
      line_tx_valid_q <= 1'b0;
      line_tx_am_q <= 1'b0;
    end else begin
      div_q <= line_en ? 2'h0 : div_q + 2'h1;
      if (wr) begin
        sop_q[wp_q] <= lnk.tx_sop;
        eop_q[wp_q] <= lnk.tx_eop;
        wp_q <= wp_q + 3'h1;
      end
      fill_q <= fill_d;
      bp_q <= fill_d >= `ETF_BP_LEVEL;
      ovf_q <= lnk.tx_valid && full;
      unf_q <= starve;
      pkt_q <= rd && eop_q[rp_q];
      if (line_en) begin
        am_cnt_q <= am_slot ? 14'h0000 : am_cnt_q + 14'h0001;
      end
      line_tx_valid_q <= rd;
      line_tx_am_q <= am_slot;
      if (rd) begin
        rp_q <= rp_q + 3'h1;
        in_pkt_q <= !eop_q[rp_q];
        line_tx_data_q <= mem_q[rp_q];
        line_tx_bip_q <= etf_pkg::etf_bip(mem_q[rp_q]);
      end else if (starve) begin
        in_pkt_q <= 1'b0;
      end
    end
  end

  assign lnk.tx_backpressure = bp_q;
  assign lnk.tx_overflow = ovf_q;
  assign lnk.tx_underflow = unf_q;
  assign lnk.stat_tx_pkt = pkt_q;

  // ----------------------------------------------------------------
  // Receive side, with local loopback of the transmit line
  // ----------------------------------------------------------------
  wire rx_v = lnk.loopback ? line_tx_valid_q : line_rx_valid;
  wire rx_a = lnk.loopback ? line_tx_am_q : line_rx_am;
  etf_pkg::etf_data_t rx_d;
  etf_pkg::etf_bip_t rx_b;
  assign rx_d = lnk.loopback ? line_tx_data_q : line_rx_data;
  assign rx_b = lnk.loopback ? line_tx_bip_q : line_rx_bip;

  etf_rxmon u_rxmon (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!lnk.core_rst_n || lnk.rx_dp_rst),
    .rx_valid(rx_v),
    .rx_am(rx_a),
    .rx_data(rx_d),
    .rx_bip(rx_b),
    .bip_err_q(lnk.rx_bip_err),
    .bip_cnt_q(lnk.stat_rx_bip_cnt),
    .hi_ber_q(lnk.rx_high_error_rate),
    .aligned_q(lnk.rx_aligned)
  );
endmodule : etf_dev

// ===== verilog/etf_host.sv
// Purpose: User-side controller: resets, transmit feed, status over APB
// Assumes: Status pins come from other domains; user source on pclk
// Notes: APB answers after one access cycle
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "etf_regs.svh"
module etf_host #(
  parameter int ALIGN_TO_CYC = `ETF_ALIGN_TO_NS / `ETF_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  etf_if.host lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  output logic irq_q,
  input wire logic clk_stable,
  input wire logic cdr_lock,
  input wire logic signal_detect,
  input wire logic usr_valid,
  input wire logic usr_sop,
  input wire logic usr_eop,
  input etf_pkg::etf_data_t usr_data,
  output logic usr_ready_q
);
  localparam int SETTLE_CYC = `ETF_SETTLE_NS / `ETF_CLK_NS;

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] f_q;
  logic [2:0] fp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      f_q <= 3'h0;
      fp_q <= 3'h0;
    end else begin
      s1_q <= {signal_detect, cdr_lock, clk_stable};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
      fp_q <= f_q;
    end
  end

  wire stable = f_q[0];
  wire cdr_lost = fp_q[1] && !f_q[1];
  wire sd_rise = f_q[2] && !fp_q[2];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [4:0] ctrl_q;
  logic [13:0] cfg_q;
  logic [`ETF_IRQ_W-1:0] ist_q;
  logic [`ETF_IRQ_W-1:0] ien_q;
  logic [31:0] cnt_pkt_q;
  logic [31:0] cnt_bip_q;
  logic halted_q;
  logic hiber_p_q;
  etf_pkg::etf_rst_st_t st_q;

  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready_q && pwrite;
  wire hit_ctrl = paddr == `ETF_OFF_CTRL;
  wire hit_cfg = paddr == `ETF_OFF_CFG;
  wire hit_clr = paddr == `ETF_OFF_IRQ_CLR;
  wire hit_en = paddr == `ETF_OFF_IRQ_EN;
  wire mapped = paddr inside {`ETF_OFF_CTRL, `ETF_OFF_CFG, `ETF_OFF_STAT,
    `ETF_OFF_IRQ_ST, `ETF_OFF_IRQ_CLR, `ETF_OFF_IRQ_EN,
    `ETF_OFF_CNT_PKT, `ETF_OFF_CNT_BIP};
  wire [31:0] status = {26'h0, f_q[2], halted_q, lnk.rx_aligned,
    lnk.rx_high_error_rate, lnk.tx_backpressure, !lnk.core_rst_n};
  wire [31:0] rdata = hit_ctrl ? {27'h0, ctrl_q} :
    hit_cfg ? {18'h0, cfg_q} :
    (paddr == `ETF_OFF_STAT) ? status :
    (paddr == `ETF_OFF_IRQ_ST) ? {27'h0, ist_q} :
    hit_en ? {27'h0, ien_q} :
    (paddr == `ETF_OFF_CNT_PKT) ? cnt_pkt_q :
    (paddr == `ETF_OFF_CNT_BIP) ? cnt_bip_q : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q <= (setup && !pwrite) ? rdata : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and interrupts
  // ----------------------------------------------------------------
  wire sw_rst = ctrl_q[`ETF_CTRL_SWRST];
  wire rx_req = wr_en && hit_ctrl && pwdata[`ETF_CTRL_RXRST];
  wire resume = wr_en && hit_ctrl && pwdata[`ETF_CTRL_RESUME];
  wire [`ETF_IRQ_W-1:0] ev = {cdr_lost, |lnk.rx_bip_err,
    lnk.rx_high_error_rate && !hiber_p_q, lnk.tx_underflow,
    lnk.tx_overflow};
  wire [`ETF_IRQ_W-1:0] iclr = (wr_en && hit_clr) ?
    pwdata[`ETF_IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ETF_CTRL_RST;
      cfg_q <= `ETF_AM_SPACING;
      ist_q <= '0;
      ien_q <= '0;
      irq_q <= 1'b0;
      halted_q <= 1'b0;
      hiber_p_q <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) begin
        ctrl_q <= {pwdata[`ETF_CTRL_TIMEOUT], 2'h0, pwdata[1:0]};
      end
      if (wr_en && hit_cfg) begin
        cfg_q <= pwdata[13:0];
      end
      if (wr_en && hit_en) begin
        ien_q <= pwdata[`ETF_IRQ_W-1:0];
      end
      ist_q <= (ist_q & ~iclr) | ev;
      irq_q <= |(((ist_q & ~iclr) | ev) & ien_q);
      hiber_p_q <= lnk.rx_high_error_rate;
      // Overflow blocks traffic until software resumes; set wins
      halted_q <= lnk.tx_overflow || (halted_q && !resume);
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencing
  // ----------------------------------------------------------------
  logic [31:0] cnt_q;
  logic [31:0] ato_q;
  logic rst_n_q;
  logic rxr_q;
  logic [13:0] lcfg_q;
  logic loop_q;
  wire kick = !stable || cdr_lost || lnk.tx_overflow || sw_rst;
  wire ato_hit = ctrl_q[`ETF_CTRL_TIMEOUT] && (ato_q == 32'(ALIGN_TO_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= etf_pkg::ST_HOLD;
      cnt_q <= 32'h0;
      ato_q <= 32'h0;
      rst_n_q <= 1'b0;
      rxr_q <= 1'b0;
      lcfg_q <= `ETF_AM_SPACING;
      loop_q <= 1'b0;
    end else begin
      loop_q <= ctrl_q[`ETF_CTRL_LOOP];
      unique case (st_q)
        etf_pkg::ST_HOLD: begin
          rst_n_q <= 1'b0;
          lcfg_q <= cfg_q;
          cnt_q <= (stable && !sw_rst) ? cnt_q + 32'h1 : 32'h0;
          if (cnt_q == 32'(SETTLE_CYC - 1)) begin
            st_q <= etf_pkg::ST_RUN;
            rst_n_q <= 1'b1;
          end
        end
        etf_pkg::ST_RUN: begin
          cnt_q <= 32'h0;
          if (kick) begin
            st_q <= etf_pkg::ST_HOLD;
            rst_n_q <= 1'b0;
          end
        end
      endcase
      // Prefer signal detect; timeout only when enabled by software
      // No receive pulse in the cycle the core is being reset
      rxr_q <= rst_n_q && !kick &&
        (sd_rise || ato_hit || rx_req);
      // Counts only while enabled, so a late enable still fires
      ato_q <= (!rst_n_q || lnk.rx_aligned || ato_hit ||
        !ctrl_q[`ETF_CTRL_TIMEOUT]) ? 32'h0 : ato_q + 32'h1;
    end
  end

  assign lnk.core_rst_n = rst_n_q;
  assign lnk.rx_dp_rst = rxr_q;
  assign lnk.cfg_am_spacing = lcfg_q;
  assign lnk.loopback = loop_q;

  // ----------------------------------------------------------------
  // Transmit feed and statistics counters
  // ----------------------------------------------------------------
  logic txv_q;
  logic txs_q;
  logic txe_q;
  etf_pkg::etf_data_t txd_q;
  wire take = usr_valid && usr_ready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usr_ready_q <= 1'b0;
      {txv_q, txs_q, txe_q} <= 3'h0;
      txd_q <= '0;
      cnt_pkt_q <= 32'h0;
      cnt_bip_q <= 32'h0;
    end else begin
      // Full bus rate, twice the line drain, no gaps inserted
      usr_ready_q <= rst_n_q && !halted_q && !lnk.tx_backpressure &&
        !lnk.tx_overflow;
      txv_q <= take;
      txs_q <= take && usr_sop;
      txe_q <= take && usr_eop;
      if (take) begin
        txd_q <= usr_data;
      end
      if (!rst_n_q) begin
        cnt_pkt_q <= 32'h0;
        cnt_bip_q <= 32'h0;
      end else begin
        cnt_pkt_q <= cnt_pkt_q + {31'h0, lnk.stat_tx_pkt};
        cnt_bip_q <= cnt_bip_q + {29'h0, lnk.stat_rx_bip_cnt};
      end
    end
  end

  assign lnk.tx_valid = txv_q;
  assign lnk.tx_sop = txs_q;
  assign lnk.tx_eop = txe_q;
  assign lnk.tx_data = txd_q;
endmodule : etf_host

// ===== tb/etf_monitor.sv
// Purpose: Link checker between host and transmit core
// Assumes: One clock, presetn async active low
// Notes: Sees only the link signals
`timescale 1ns/1ps
module etf_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_rst_n,
  input wire logic rx_dp_rst,
  input wire logic [13:0] cfg_am_spacing,
  input wire logic tx_valid,
  input wire logic tx_backpressure,
  input wire logic tx_overflow,
  input wire logic tx_underflow,
  input wire logic [3:0] rx_bip_err,
  input wire logic stat_tx_pkt,
  input wire logic [2:0] stat_rx_bip_cnt
);
  // Idle run length, saturating; 20 idle cycles drain a full buffer
  logic [4:0] idle_q;
  logic [4:0] idle_d;
  logic idle_sat;
  assign idle_sat = (idle_q == 5'h1f);
  assign idle_d = tx_valid ? 5'h00 : (idle_sat ? idle_q : idle_q + 5'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 5'h00;
    end else begin
      idle_q <= idle_d;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cfg_hold_run: assert property (
    core_rst_n && $past(core_rst_n) |-> $stable(cfg_am_spacing))
    else $error("spacing changed outside core reset");
  a_bp_stops_writes: assert property (
    tx_backpressure ##1 tx_backpressure |=> !tx_valid)
    else $error("write issued under backpressure");
  a_bp_releases: assert property (
    idle_q >= 5'h14 |-> !tx_backpressure)
    else $error("backpressure stuck on drained buffer");
  a_no_overflow: assert property (!tx_overflow)
    else $error("overflow while backpressure obeyed");
  a_no_underflow: assert property (!tx_underflow)
    else $error("underflow with gapless feed");
  a_bip_count: assert property (
    stat_rx_bip_cnt == 3'($countones(rx_bip_err)))
    else $error("lane error count differs from lane flags");
  a_pkt_strobe: assert property (stat_tx_pkt |=> !stat_tx_pkt)
    else $error("packet strobe longer than one cycle");
  a_rxrst_pulse: assert property (rx_dp_rst |=> !rx_dp_rst)
    else $error("receive reset not a single pulse");
  a_rxrst_tx_runs: assert property (rx_dp_rst |-> core_rst_n)
    else $error("receive reset while core held");
endmodule : etf_monitor

// ===== tb/etf_tb_top.sv
// Purpose: Self-checking bench for host, core and link
// Assumes: 100 MHz pclk, short alignment timeout
// Notes: Second link lets the bench break the feed rules
`timescale 1ns/1ps
`include "etf_regs.svh"
module etf_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic clk_stable = 1'b0;
  logic cdr_lock = 1'b1;
  logic signal_detect = 1'b0;
  logic usr_valid = 1'b0;
  logic usr_sop = 1'b0;
  logic usr_eop = 1'b0;
  etf_pkg::etf_data_t usr_data = '0;
  logic usr_ready_q;
  logic [31:0] bip_flip = 32'h0;
  logic lv, la, l2v, l2a;
  etf_pkg::etf_data_t ld, l2d;
  etf_pkg::etf_bip_t lb, l2b;
  logic [31:0] rv;
  logic re;
  logic [3:0] seen;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  wire logic [4:0] ev;
  etf_if lnk (.pclk(pclk));
  etf_if lnk2 (.pclk(pclk));
  assign ev = {lnk2.tx_underflow, lnk2.tx_overflow, lnk2.tx_backpressure,
               lnk.core_rst_n, lnk.rx_dp_rst};
  always #5 pclk = ~pclk;
  etf_host #(.ALIGN_TO_CYC(50)) etf_host_inst (.pclk(pclk),
    .presetn(presetn), .lnk(lnk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .irq_q(irq_q),
    .clk_stable(clk_stable), .cdr_lock(cdr_lock),
    .signal_detect(signal_detect), .usr_valid(usr_valid),
    .usr_sop(usr_sop), .usr_eop(usr_eop), .usr_data(usr_data),
    .usr_ready_q(usr_ready_q));
  // Local loopback on the line; bip_flip injects lane parity faults
  etf_dev etf_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .line_tx_valid_q(lv), .line_tx_am_q(la), .line_tx_data_q(ld),
    .line_tx_bip_q(lb), .line_rx_valid(lv), .line_rx_am(la),
    .line_rx_data(ld), .line_rx_bip(lb ^ bip_flip));
  etf_dev etf_dev_inst_b (.pclk(pclk), .presetn(presetn), .lnk(lnk2),
    .line_tx_valid_q(l2v), .line_tx_am_q(l2a), .line_tx_data_q(l2d),
    .line_tx_bip_q(l2b), .line_rx_valid(l2v), .line_rx_am(l2a),
    .line_rx_data(l2d), .line_rx_bip(l2b));
  etf_monitor etf_monitor_inst (.pclk(pclk), .presetn(presetn),
    .core_rst_n(lnk.core_rst_n), .rx_dp_rst(lnk.rx_dp_rst),
    .cfg_am_spacing(lnk.cfg_am_spacing), .tx_valid(lnk.tx_valid),
    .tx_backpressure(lnk.tx_backpressure), .tx_overflow(lnk.tx_overflow),
    .tx_underflow(lnk.tx_underflow), .rx_bip_err(lnk.rx_bip_err),
    .stat_tx_pkt(lnk.stat_tx_pkt), .stat_rx_bip_cnt(lnk.stat_rx_bip_cnt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_q !== 1'b1);
    r = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, re);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
      input string nm);
    apb(1'b0, a, 32'h0, rv, re);
    chk(nm, x, rv);
  endtask : rdchk
  // Bounded wait for one watched link bit to reach a level
  task automatic wt(input int b, input logic v, input int lim,
      input string nm);
    int n;
    n = 0;
    while (ev[b] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, 32'h1, 32'(n < lim));
  endtask : wt
  task automatic send(input int n);
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      usr_valid <= 1'b1;
      usr_sop <= (i == 0);
      usr_eop <= (i == n - 1);
      usr_data <= {16{32'(i)}};
      do @(posedge pclk); while (usr_ready_q !== 1'b1);
    end
    usr_valid <= 1'b0;
  endtask : send
  // One beat with line parity faults; lane flags gathered in seen
  task automatic lanes(input logic [31:0] f);
    bip_flip <= f;
    send(1);
    seen = 4'h0;
    repeat (20) begin
      @(posedge pclk);
      seen = seen | lnk.rx_bip_err;
    end
    bip_flip <= 32'h0;
  endtask : lanes
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int n;
    lnk2.core_rst_n = 1'b0;
    lnk2.rx_dp_rst = 1'b0;
    lnk2.cfg_am_spacing = 14'h3fff;
    lnk2.loopback = 1'b0;
    lnk2.tx_valid = 1'b0;
    lnk2.tx_sop = 1'b0;
    lnk2.tx_eop = 1'b0;
    lnk2.tx_data = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    lnk2.core_rst_n <= 1'b1;
    rdchk(`ETF_OFF_CFG, 32'h3fff, "cfg reset");
    rdchk(`ETF_OFF_STAT, 32'h1, "status in hold");
    rdchk(`ETF_OFF_CTRL, 32'h0, "ctrl reset");
    apb(1'b0, 8'h40, 32'h0, rv, re);
    chk("unmapped error", 32'h1, {31'h0, re});
    repeat (50) @(posedge pclk);
    chk("core held", 32'h0, {31'h0, lnk.core_rst_n});
    clk_stable <= 1'b1;
    n = 0;
    while (lnk.core_rst_n !== 1'b1 && n < 1100) begin
      @(posedge pclk);
      n++;
    end
    chk("settle window", 32'h1, 32'(n >= 1000 && n < 1100));
    wr(`ETF_OFF_IRQ_EN, 32'h1f);
    // Three long packets overrun the threshold and exercise stalls
    send(6);
    send(6);
    send(6);
    repeat (100) @(posedge pclk);
    rdchk(`ETF_OFF_CNT_PKT, 32'h3, "packet count");
    rdchk(`ETF_OFF_IRQ_ST, 32'h0, "no flow faults");
    lanes(32'h0001_0001);
    chk("lane flags", 32'h5, {28'h0, seen});
    chk("irq raised", 32'h1, {31'h0, irq_q});
    rdchk(`ETF_OFF_IRQ_ST, 32'h8, "irq status bip");
    wr(`ETF_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq_q});
    wr(`ETF_OFF_IRQ_CLR, 32'h1f);
    rdchk(`ETF_OFF_IRQ_ST, 32'h0, "irq cleared");
    wr(`ETF_OFF_IRQ_EN, 32'h1f);
    wr(`ETF_OFF_CTRL, 32'h6);
    wt(0, 1'b1, 5, "rx reset pulse");
    chk("core kept running", 32'h1, {31'h0, lnk.core_rst_n});
    wt(0, 1'b0, 5, "rx reset ends");
    signal_detect <= 1'b1;
    wt(0, 1'b1, 10, "rx reset on detect");
    chk("loopback on", 32'h1, {31'h0, lnk.loopback});
    // Loopback bypasses the line, so line faults must not show
    lanes(32'hffff_ffff);
    chk("loopback bypass", 32'h0, {28'h0, seen});
    // New spacing must wait for the next core reset
    wr(`ETF_OFF_CFG, 32'h0fff);
    chk("spacing held", 32'h3fff, {18'h0, lnk.cfg_am_spacing});
    cdr_lock <= 1'b0;
    wt(1, 1'b0, 10, "reset on lock loss");
    cdr_lock <= 1'b1;
    wt(1, 1'b1, 1200, "core back");
    chk("spacing applied", 32'h0fff, {18'h0, lnk.cfg_am_spacing});
    rdchk(`ETF_OFF_CNT_PKT, 32'h0, "count cleared");
    rdchk(`ETF_OFF_IRQ_ST, 32'h10, "irq lock loss");
    wr(`ETF_OFF_CTRL, 32'h10);
    wt(0, 1'b1, 60, "rx reset on timeout");
    // Second link: ignore backpressure, then starve mid-packet
    lnk2.tx_valid <= 1'b1;
    lnk2.tx_sop <= 1'b1;
    @(posedge pclk);
    lnk2.tx_sop <= 1'b0;
    wt(2, 1'b1, 20, "backpressure rises");
    wt(3, 1'b1, 40, "overflow flagged");
    lnk2.tx_valid <= 1'b0;
    wt(2, 1'b0, 30, "backpressure falls");
    wt(4, 1'b1, 40, "underflow flagged");
    report_and_stop();
  end
endmodule : etf_tb_top
